// >>> pkg/wdw_pkg.sv
// Constants shared by the windowed watchdog modules
package wdw_pkg;
	// **********
	// Clocks
	// **********
	localparam int unsigned CLK_HZ   = 100_000_000;
	localparam int unsigned RC_HZ    = 32_000;
	localparam int unsigned RC_CYC   = CLK_HZ / RC_HZ;
	localparam int          RC_W     = 12;

	// **********
	// Prescaler and postscaler
	// **********
	localparam int          PRE_W      = 7;
	localparam logic [6:0]  PRE32_LAST = 7'h1F;
	localparam logic [6:0]  PRE128_LAST = 7'h7F;
	localparam logic [4:0]  PRE32_SH   = 5'h05;
	localparam logic [4:0]  PRE128_SH  = 5'h07;
	localparam int          BASE_MS_32  = 1;
	localparam int          BASE_MS_128 = 4;
	localparam int          POST_W     = 15;
	localparam int          SEL_W      = 4;
	localparam int          EL_W       = 23;

	// **********
	// Core power state
	// **********
	typedef enum logic {WDW_RUN, WDW_SLEEP} wdw_mode_e;
endpackage

// >>> pkg/wdw_if.sv
// Link between watchdog core and its prescaler
`timescale 1ns/1ns
interface wdw_if;
	logic                      rc_tick;
	logic                      clear;
	logic                      pre_sel;
	logic [wdw_pkg::PRE_W-1:0] pre_cnt;
	logic                      pre_tick;

	modport core (output rc_tick, output clear, output pre_sel,
		input pre_cnt, input pre_tick);
	modport pre (input rc_tick, input clear, input pre_sel,
		output pre_cnt, output pre_tick);
endinterface

// >>> logic/wdw_prescaler.sv
// Divide-by-32 or divide-by-128 watchdog prescaler
`timescale 1ns/1ns
module wdw_prescaler (
	input  wire logic clk,
	input  wire logic srst,
	wdw_if.pre        p
);
	typedef struct packed {
		logic [wdw_pkg::PRE_W-1:0] cnt;
	} wdw_pre_s;

	wdw_pre_s st;
	wdw_pre_s next_st;
	logic [wdw_pkg::PRE_W-1:0] last;

	assign last       = p.pre_sel ? wdw_pkg::PRE128_LAST : wdw_pkg::PRE32_LAST;
	assign p.pre_cnt  = st.cnt;
	// Restart masking is done by the core, keeping this path free of the clear
	assign p.pre_tick = p.rc_tick && (st.cnt == last);

	always_comb begin
		next_st = st;
		if (p.clear) begin
			next_st.cnt = '0;
		end else if (p.rc_tick) begin
			next_st.cnt = (st.cnt == last) ? '0 : st.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// >>> logic/wdw_top.sv
// Windowed watchdog timer with sleep wake-up and time-out flag
// Function
// - Runs from 32 kHz RC, enabling it
// - Prescaler divides by 32 or 128
// - Base time-out 1 ms or 4 ms
// - Four-bit postscaler, sixteen ratios up to 32768
// - Any device reset clears all counters
// - Completed clock switch clears prescaler and postscaler
// - Sleep/idle entry and exit clear counters
// - Clear instruction resets counter and scalers
// - Time-out in sleep wakes, no reset
// - Time-out flag sticky until software clears
// - Force-enable bit keeps watchdog always running
// - Otherwise runs only with software enable
// - Device reset clears software enable bit
// - Early clear in window mode resets
// - Prescale bit one selects divide-by-128
// - Postscale code 1111 gives 1:32768
// - Window-disable bit one means non-window
`timescale 1ns/1ns
module wdw_top #(
	parameter int unsigned RC_CYC = wdw_pkg::RC_CYC
) (
	input  wire logic                      clk,
	input  wire logic                      srst,
	input  wire logic                      force_enable_config_bit,
	input  wire logic                      window_disable_bit,
	input  wire logic                      prescale_select_bit,
	input  wire logic [wdw_pkg::SEL_W-1:0] postscale_select_field,
	input  wire logic                      software_enable_wr,
	input  wire logic                      software_enable_wdata,
	input  wire logic                      watchdog_clear_instr,
	input  wire logic                      power_save_instr,
	input  wire logic                      wake_exit,
	input  wire logic                      clk_switch_done,
	input  wire logic                      expired_flag_clr,
	output logic                           software_enable_bit,
	output logic                           watchdog_expired_flag,
	output logic                           low_power_rc_enable,
	output logic                           watchdog_reset_req,
	output logic                           watchdog_wake,
	output logic                           in_power_save
);
	// **********
	// State
	// **********
	typedef struct packed {
		wdw_pkg::wdw_mode_e          mode;
		logic                        sw_en;
		logic                        flag;
		logic [wdw_pkg::RC_W-1:0]    rc_cnt;
		logic [wdw_pkg::POST_W-1:0]  post_cnt;
		logic                        rst_req;
		logic                        wake;
	} wdw_state_s;

	wdw_state_s st;
	wdw_state_s next_st;

	localparam logic [wdw_pkg::RC_W-1:0] RC_LAST = wdw_pkg::RC_W'(RC_CYC - 1);

	wdw_if pif ();

	logic                       enabled;
	logic                       clr_req;
	logic                       clr_ok;
	logic                       clr_early;
	logic                       restart;
	logic                       timeout;
	logic                       exit_ps;
	logic [wdw_pkg::POST_W-1:0] post_last;
	logic [4:0]                 pre_sh;
	logic [wdw_pkg::EL_W-1:0]   elapsed;
	logic [wdw_pkg::EL_W-1:0]   period;
	logic [wdw_pkg::EL_W-1:0]   win_start;
	logic                       win_open;

	wdw_prescaler u_pre (
		.clk  (clk),
		.srst (srst),
		.p    (pif.pre)
	);

	// **********
	// Enable and clocking
	// **********
	assign enabled             = force_enable_config_bit || st.sw_en;
	assign low_power_rc_enable = enabled;
	assign pif.rc_tick         = enabled && (st.rc_cnt == RC_LAST);
	assign pif.pre_sel         = prescale_select_bit;

	// **********
	// Postscaler and window
	// **********
	// Base period is 32 or 128 RC ticks: 1 ms or 4 ms at 32 kHz
	assign pre_sh    = prescale_select_bit ? wdw_pkg::PRE128_SH : wdw_pkg::PRE32_SH;
	assign post_last = wdw_pkg::POST_W'((16'h0001 << postscale_select_field) - 16'h0001);
	assign timeout   = pif.pre_tick && (st.post_cnt == post_last) && !restart;
	assign period    = wdw_pkg::EL_W'(1) << (pre_sh + 5'(postscale_select_field));
	assign win_start = period - (period >> 2);
	assign elapsed   = (wdw_pkg::EL_W'(st.post_cnt) << pre_sh) | wdw_pkg::EL_W'(pif.pre_cnt);
	assign win_open  = window_disable_bit || (elapsed >= win_start);

	assign clr_req   = watchdog_clear_instr && enabled && (st.mode == wdw_pkg::WDW_RUN);
	assign clr_early = clr_req && !win_open;
	assign clr_ok    = clr_req && win_open;
	assign restart   = !enabled || clr_req || clk_switch_done || power_save_instr
		|| ((st.mode == wdw_pkg::WDW_SLEEP) && wake_exit);
	assign exit_ps   = (st.mode == wdw_pkg::WDW_SLEEP) && (wake_exit || timeout);

	// Time-out also restarts the scalers
	assign pif.clear = restart || timeout;

	// **********
	// Next state
	// **********
	always_comb begin
		next_st         = st;
		next_st.rst_req = 1'b0;
		next_st.wake    = 1'b0;
		if (software_enable_wr) begin
			next_st.sw_en = software_enable_wdata;
		end
		if (!enabled) begin
			next_st.rc_cnt = '0;
		end else begin
			next_st.rc_cnt = (st.rc_cnt == RC_LAST) ? '0 : st.rc_cnt + 1'b1;
		end
		if (expired_flag_clr) begin
			next_st.flag = 1'b0;
		end
		if (pif.clear) begin
			next_st.post_cnt = '0;
		end else if (pif.pre_tick) begin
			next_st.post_cnt = st.post_cnt + 1'b1;
		end
		if (st.mode == wdw_pkg::WDW_RUN && power_save_instr) begin
			next_st.mode = wdw_pkg::WDW_SLEEP;
		end else if (exit_ps) begin
			next_st.mode = wdw_pkg::WDW_RUN;
		end
		if (timeout) begin
			next_st.flag = 1'b1;
			if (st.mode == wdw_pkg::WDW_SLEEP) begin
				next_st.wake = 1'b1;
			end else begin
				next_st.rst_req = 1'b1;
			end
		end
		if (clr_early) begin
			next_st.flag    = 1'b1;
			next_st.rst_req = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st      <= '0;
			st.mode <= wdw_pkg::WDW_RUN;
		end else begin
			st <= next_st;
		end
	end

	// **********
	// Outputs
	// **********
	assign software_enable_bit   = st.sw_en;
	assign watchdog_expired_flag = st.flag;
	assign watchdog_reset_req    = st.rst_req;
	assign watchdog_wake         = st.wake;
	assign in_power_save         = (st.mode == wdw_pkg::WDW_SLEEP);

	// **********
	// Checks
	// **********
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence enter_ps_s;
		power_save_instr && st.mode == wdw_pkg::WDW_RUN;
	endsequence

	sequence scalers_zero_s;
		st.post_cnt == '0 && pif.pre_cnt == '0;
	endsequence

	early_clear_a: assert property (clr_early |=> watchdog_reset_req && watchdog_expired_flag)
		else $error("early clear did not reset");
	late_clear_a: assert property (clr_ok && !timeout |=> !watchdog_reset_req ##0 scalers_zero_s)
		else $error("clear in window misbehaved");
	flag_hold_a: assert property (watchdog_expired_flag && !expired_flag_clr |=> watchdog_expired_flag)
		else $error("flag dropped by itself");
	sleep_wake_a: assert property (timeout && in_power_save |=> watchdog_wake && !watchdog_reset_req
		&& !in_power_save)
		else $error("sleep time-out not a wake");
	run_reset_a: assert property (timeout && !in_power_save |=> watchdog_reset_req
		&& watchdog_expired_flag)
		else $error("run time-out not a reset");
	force_run_a: assert property (force_enable_config_bit |-> low_power_rc_enable)
		else $error("forced watchdog not running");
	disabled_idle_a: assert property (!force_enable_config_bit && !st.sw_en |=> st.post_cnt == '0)
		else $error("disabled watchdog counted");
	enter_ps_a: assert property (enter_ps_s |=> in_power_save ##0 scalers_zero_s)
		else $error("sleep entry did not clear");
	switch_clr_a: assert property (clk_switch_done |=> scalers_zero_s)
		else $error("clock switch did not clear");
	timeout_clr_a: assert property (timeout |=> scalers_zero_s)
		else $error("time-out did not restart");
	sw_write_a: assert property (software_enable_wr |=>
		software_enable_bit == $past(software_enable_wdata))
		else $error("software enable not written");
	post_bound_a: assert property (st.post_cnt <= post_last || $changed(postscale_select_field)
		|| $past(postscale_select_field) != postscale_select_field)
		else $error("postscaler beyond ratio");
endmodule

// >>> bench/wdw_top_tb.sv
// Self-checking bench for the windowed watchdog
`timescale 1ns/1ns
module wdw_top_tb;
	logic       clk, srst, force_en, win_dis, pre_sel, sw_wr, sw_wd;
	logic       clr, psave, wake_x, csw, fclr;
	logic [3:0] post;
	logic [5:0] pls;
	logic       sw_en, flag, rc_en, rst_req, wake, in_ps;
	int         bad_count = 0;
	int         samples_checked = 0;

	assign {fclr, sw_wr, csw, wake_x, psave, clr} = pls;

	wdw_top #(.RC_CYC(2)) wdw_top_inst (.clk(clk), .srst(srst),
		.force_enable_config_bit(force_en), .window_disable_bit(win_dis),
		.prescale_select_bit(pre_sel), .postscale_select_field(post),
		.software_enable_wr(sw_wr), .software_enable_wdata(sw_wd),
		.watchdog_clear_instr(clr), .power_save_instr(psave), .wake_exit(wake_x),
		.clk_switch_done(csw), .expired_flag_clr(fclr), .software_enable_bit(sw_en),
		.watchdog_expired_flag(flag), .low_power_rc_enable(rc_en),
		.watchdog_reset_req(rst_req), .watchdog_wake(wake), .in_power_save(in_ps));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// **********
	// Helpers
	// **********
	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Cycle counts may differ by pipeline slack of a few clocks
	task automatic check_count(input int got, input int exp);
		samples_checked++;
		if (got < exp - 3 || got > exp + 3) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic pulse(input int k);
		pls[k] = 1'b1;
		@(negedge clk);
		pls[k] = 1'b0;
	endtask

	// Counts falling edges until reset request or wake, at most lim
	task automatic wait_evt(input bit must, input int lim, output int n);
		for (n = 1; n <= lim; n++) begin
			@(negedge clk);
			if (rst_req === 1'b1 || wake === 1'b1) begin
				return;
			end
		end
		if (must) begin
			bad_count++;
			summarize();
		end
	endtask

	task automatic do_reset;
		srst = 1'b1;
		repeat (8) @(negedge clk);
		srst = 1'b0;
		check_bit(sw_en, 1'b0);
		check_bit(flag, 1'b0);
		check_bit(rc_en, force_en);
	endtask

	// **********
	// Scenarios
	// **********
	task automatic t_enable;
		int n;
		wait_evt(0, 600, n);
		check_count(n, 601);
		sw_wd = 1'b1;
		pulse(4);
		check_bit(sw_en, 1'b1);
		check_bit(rc_en, 1'b1);
		wait_evt(1, 3000, n);
		check_count(n, 128);
		sw_wd = 1'b0;
		pulse(4);
		force_en = 1'b1;
		@(negedge clk);
		check_bit(rc_en, 1'b1);
		pulse(5);
		wait_evt(1, 3000, n);
		check_bit(rst_req, 1'b1);
		repeat (40) @(negedge clk);
		do_reset();
		wait_evt(1, 3000, n);
		check_count(n, 128);
		$display("enable test done");
	endtask

	task automatic t_period(input logic p, input logic [3:0] c);
		int n;
		pre_sel = p;
		post = c;
		pulse(0);
		wait_evt(1, 3000, n);
		check_count(n, 2 * (p ? 128 : 32) * (1 << c));
		check_bit(rst_req, 1'b1);
		check_bit(flag, 1'b1);
		repeat (3) @(negedge clk);
		check_bit(flag, 1'b1);
		pulse(5);
		@(negedge clk);
		check_bit(flag, 1'b0);
		$display("period test %0d %0d done", p, c);
	endtask

	task automatic t_restart(input int k);
		int n;
		pre_sel = 1'b0;
		post = 4'h1;
		pulse(0);
		wait_evt(0, 80, n);
		check_count(n, 81);
		pulse(k);
		wait_evt(1, 3000, n);
		check_count(n, 128);
		check_bit(wake, k == 1);
		check_bit(rst_req, k != 1);
		@(negedge clk);
		check_bit(in_ps, 1'b0);
		pulse(5);
		$display("restart test %0d done", k);
	endtask

	task automatic t_sleep_exit;
		int n;
		pulse(1);
		check_bit(in_ps, 1'b1);
		wait_evt(0, 60, n);
		pulse(2);
		check_bit(in_ps, 1'b0);
		wait_evt(1, 3000, n);
		check_count(n, 128);
		pulse(5);
		$display("sleep exit test done");
	endtask

	task automatic t_window;
		int n;
		win_dis = 1'b0;
		pulse(3);
		wait_evt(0, 40, n);
		pulse(0);
		check_bit(rst_req, 1'b1);
		check_bit(flag, 1'b1);
		pulse(5);
		pulse(3);
		wait_evt(0, 110, n);
		pulse(0);
		check_bit(rst_req, 1'b0);
		wait_evt(0, 20, n);
		check_count(n, 21);
		win_dis = 1'b1;
		pulse(5);
		$display("window test done");
	endtask

	// **********
	// Main sequence
	// **********
	initial begin
		{srst, force_en, win_dis, pre_sel, sw_wd} = 5'h15;
		pls = 6'h00;
		post = 4'h1;
		do_reset();
		t_enable();
		for (int p = 0; p < 2; p++) begin
			for (int c = 0; c < 3; c++) begin
				t_period(p[0], c[3:0]);
			end
		end
		t_restart(0);
		t_restart(3);
		t_restart(1);
		t_sleep_exit();
		t_window();
		summarize();
	end
endmodule
